//--- design/tsd_consts.vh
// constants of the touch digitizer pin interface
// assumes inclusion by bare name from the design files
`ifndef TSD_CONSTS_VH
`define TSD_CONSTS_VH

// ----------------------------------------------------------------------------
// converter channel codes
// ----------------------------------------------------------------------------
`define TSD_CH_XPOS          3'h0
`define TSD_CH_YPOS          3'h1
`define TSD_CH_YNEG          3'h2
`define TSD_CH_AUX1          3'h3
`define TSD_CH_AUX2          3'h4
`define TSD_CH_AUX3          3'h5
`define TSD_CH_SUPPLY1       3'h6
`define TSD_CH_SUPPLY2       3'h7

// ----------------------------------------------------------------------------
// serial frame and result word layout
// ----------------------------------------------------------------------------
`define TSD_FRAME_BITS       16
`define TSD_BIT_CNT_LAST     4'hf
`define TSD_WORD_MSB         15
`define TSD_WORD_CHAN_LSB    12
`define TSD_RESULT_BITS      12

// ----------------------------------------------------------------------------
// buffering and timing counts
// ----------------------------------------------------------------------------
`define TSD_FIFO_WIDTH       16
`define TSD_FIFO_DEPTH       16
`define TSD_FIFO_AW          4
`define TSD_ACQ_CYCLES       8'h10

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TSD_RST_EVENT_N      1'h1
`define TSD_RST_WORD         16'h0000

`endif

//--- design/tsd_fifo.v
// result buffer between the conversion engine and the serial shifter
// assumes one clock, depth a power of two with 2**AW == DEPTH
`timescale 1ns/1ps

module tsd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    // ------------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------------
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW:0]      wr_ptr;
    reg  [AW:0]      rd_ptr;
    wire             full;
    wire             empty;
    wire             do_write;
    wire             do_read;

    assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty       = (wr_ptr == rd_ptr);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign do_write    = in_valid_i & ~full;
    assign do_read     = out_ready_i & ~empty;

    always @(posedge clk_i) begin
        if (do_write) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (do_write) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_read) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule

//--- design/tsd_pin_if.v
// pin interface of the touch digitizer: serial port, event outputs,
// converter channel steering and logic pins
// assumes the host masters the serial port and the converter runs on clk_i
// Functional notes
// - channels 0,1,2 are x plus, y plus, y minus
// - aux inputs are channels 3-5, gpio capable
// - supply monitors are channels 6 and 7
// - touch output active low, idles high
// - select low starts conversion, enables shifter
// - serial input captured on shift clock rise
// - acquisition hold suspends converter acquisition
// - alert low on gpio bit or range fault
// - result ready low when results buffered
// - serial output bits launched on falling edge
// - serial output released while select high
// - one dedicated bidirectional logic pin
`timescale 1ns/1ps
`include "tsd_consts.vh"

module tsd_pin_if #(
    parameter [7:0] ACQ_CYCLES = `TSD_ACQ_CYCLES,
    parameter       FIFO_DEPTH = `TSD_FIFO_DEPTH,
    parameter       FIFO_AW    = `TSD_FIFO_AW
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        shift_clock_i,
    input  wire        cs_n_i,
    input  wire        sdi_i,
    output reg         sdo_o,
    output reg         sdo_oe_o,
    input  wire        acquisition_hold_i,
    input  wire        pen_contact_i,
    output reg         touch_detect_n_o,
    input  wire [2:0]  conv_chan_i,
    output reg  [7:0]  mux_sel_o,
    output reg         acq_active_o,
    output reg         conv_start_o,
    input  wire        conv_done_i,
    input  wire [11:0] conv_data_i,
    input  wire        aux1_oor_i,
    input  wire        temp_oor_i,
    input  wire        supply1_oor_i,
    input  wire        supply2_oor_i,
    output reg         alert_n_o,
    output reg         result_ready_n_o,
    input  wire [2:0]  aux_gpio_en_i,
    input  wire [3:0]  gpio_dir_i,
    input  wire [3:0]  gpio_out_i,
    input  wire [3:0]  gpio_pin_i,
    output reg  [3:0]  gpio_pin_o,
    output reg  [3:0]  gpio_pin_oe_o,
    output reg  [3:0]  gpio_in_o,
    output reg  [15:0] rx_word_o,
    output reg         rx_valid_o
);

    // ------------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ACQ  = 4'h2;
    localparam [3:0] ST_CONV = 4'h4;
    localparam [3:0] ST_PUSH = 4'h8;

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    reg         sclk_meta;
    reg         sclk_s;
    reg         sclk_prev;
    reg         cs_meta;
    reg         cs_s;
    reg         cs_prev;
    reg         sdi_meta;
    reg         sdi_s;
    reg         hold_meta;
    reg         hold_s;
    reg         pen_meta;
    reg         pen_s;
    reg  [3:0]  gpio_meta;
    reg  [3:0]  gpio_s;

    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [7:0]  acq_cnt;
    reg  [7:0]  next_acq_cnt;
    reg  [2:0]  cur_chan;
    reg  [11:0] conv_word;

    reg  [3:0]  bit_cnt;
    reg  [15:0] rx_shift;
    reg  [15:0] tx_shift;

    wire        sclk_rise;
    wire        sclk_fall;
    wire        cs_fall;
    wire        cs_active;
    wire        fifo_in_valid;
    wire        fifo_in_ready;
    wire [15:0] fifo_in_data;
    wire        fifo_out_valid;
    wire        fifo_pop;
    wire [15:0] fifo_out_data;
    wire [2:0]  sel_chan;
    wire [7:0]  chan_onehot;
    wire [7:0]  chan_block;
    wire [3:0]  gpio_en;
    wire [3:0]  gpio_data;
    wire        range_fault;

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_meta <= 1'h0;
            sclk_s    <= 1'h0;
            sclk_prev <= 1'h0;
            cs_meta   <= 1'h1;
            cs_s      <= 1'h1;
            cs_prev   <= 1'h1;
            sdi_meta  <= 1'h0;
            sdi_s     <= 1'h0;
            hold_meta <= 1'h0;
            hold_s    <= 1'h0;
            pen_meta  <= 1'h0;
            pen_s     <= 1'h0;
            gpio_meta <= 4'h0;
            gpio_s    <= 4'h0;
        end else begin
            sclk_meta <= shift_clock_i;
            sclk_s    <= sclk_meta;
            sclk_prev <= sclk_s;
            cs_meta   <= cs_n_i;
            cs_s      <= cs_meta;
            cs_prev   <= cs_s;
            sdi_meta  <= sdi_i;
            sdi_s     <= sdi_meta;
            hold_meta <= acquisition_hold_i;
            hold_s    <= hold_meta;
            pen_meta  <= pen_contact_i;
            pen_s     <= pen_meta;
            gpio_meta <= gpio_pin_i;
            gpio_s    <= gpio_meta;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev;
    assign sclk_fall = ~sclk_s & sclk_prev;
    assign cs_fall   = ~cs_s & cs_prev;
    assign cs_active = ~cs_s;

    // ------------------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------------------
    always @* begin
        next_state   = state;
        next_acq_cnt = acq_cnt;
        case (state)
            ST_IDLE: begin
                if (cs_fall) begin
                    next_state   = ST_ACQ;
                    next_acq_cnt = 8'h00;
                end
            end
            ST_ACQ: begin
                if (!hold_s) begin
                    if (acq_cnt == ACQ_CYCLES - 8'h01) begin
                        next_state = ST_CONV;
                    end else begin
                        next_acq_cnt = acq_cnt + 8'h01;
                    end
                end
            end
            ST_CONV: begin
                if (conv_done_i) begin
                    next_state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (fifo_in_ready) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state        <= ST_IDLE;
            acq_cnt      <= 8'h00;
            cur_chan     <= `TSD_CH_XPOS;
            conv_word    <= 12'h000;
            conv_start_o <= 1'h0;
            acq_active_o <= 1'h0;
            mux_sel_o    <= 8'h00;
        end else begin
            state        <= next_state;
            acq_cnt      <= next_acq_cnt;
            conv_start_o <= (state == ST_ACQ) && (next_state == ST_CONV);
            acq_active_o <= (next_state == ST_ACQ) && !hold_s;
            if (state == ST_IDLE && cs_fall) begin
                cur_chan <= conv_chan_i;
            end
            if (state == ST_CONV && conv_done_i) begin
                conv_word <= conv_data_i;
            end
            if (next_state == ST_ACQ || next_state == ST_CONV) begin
                mux_sel_o <= chan_onehot & ~chan_block;
            end else begin
                mux_sel_o <= 8'h00;
            end
        end
    end

    // channel steering: aux channels in logic mode are taken off the mux
    assign sel_chan    = (state == ST_IDLE && cs_fall) ? conv_chan_i : cur_chan;
    assign chan_onehot = 8'h01 << sel_chan;
    assign chan_block  = {5'h00, aux_gpio_en_i} << `TSD_CH_AUX1;

    // ------------------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------------------
    assign fifo_in_valid = (state == ST_PUSH);
    assign fifo_in_data  = {1'h0, cur_chan, conv_word};
    assign fifo_pop      = cs_fall & fifo_out_valid;

    tsd_fifo #(
        .WIDTH (`TSD_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_out_data)
    );

    // ------------------------------------------------------------------------
    // serial shifter
    // ------------------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt    <= 4'h0;
            rx_shift   <= `TSD_RST_WORD;
            tx_shift   <= `TSD_RST_WORD;
            rx_word_o  <= `TSD_RST_WORD;
            rx_valid_o <= 1'h0;
            sdo_o      <= 1'h0;
            sdo_oe_o   <= 1'h0;
        end else begin
            rx_valid_o <= 1'h0;
            sdo_oe_o   <= cs_active;
            if (!cs_active) begin
                bit_cnt  <= 4'h0;
                rx_shift <= `TSD_RST_WORD;
                sdo_o    <= 1'h0;
            end else if (cs_fall) begin
                bit_cnt <= 4'h0;
                if (fifo_out_valid) begin
                    tx_shift <= fifo_out_data;
                    sdo_o    <= fifo_out_data[`TSD_WORD_MSB];
                end else begin
                    tx_shift <= `TSD_RST_WORD;
                    sdo_o    <= 1'h0;
                end
            end else begin
                if (sclk_rise) begin
                    rx_shift <= {rx_shift[14:0], sdi_s};
                    bit_cnt  <= bit_cnt + 4'h1;
                    if (bit_cnt == `TSD_BIT_CNT_LAST) begin
                        rx_word_o  <= {rx_shift[14:0], sdi_s};
                        rx_valid_o <= 1'h1;
                    end
                end
                if (sclk_fall) begin
                    tx_shift <= {tx_shift[14:0], 1'h0};
                    sdo_o    <= tx_shift[14];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // logic pins: bits 0 to 2 share the aux inputs, bit 3 is dedicated
    // ------------------------------------------------------------------------
    assign gpio_en = {1'h1, aux_gpio_en_i};

    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_gpio
            assign gpio_data[k] = gpio_en[k] & (gpio_dir_i[k] ? gpio_out_i[k] : gpio_s[k]);
            always @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    gpio_pin_o[k]    <= 1'h0;
                    gpio_pin_oe_o[k] <= 1'h0;
                    gpio_in_o[k]     <= 1'h0;
                end else begin
                    gpio_pin_o[k]    <= gpio_out_i[k];
                    gpio_pin_oe_o[k] <= gpio_en[k] & gpio_dir_i[k];
                    gpio_in_o[k]     <= gpio_s[k];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // event outputs
    // ------------------------------------------------------------------------
    assign range_fault = aux1_oor_i | temp_oor_i | supply1_oor_i | supply2_oor_i;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            touch_detect_n_o <= `TSD_RST_EVENT_N;
            alert_n_o        <= `TSD_RST_EVENT_N;
            result_ready_n_o <= `TSD_RST_EVENT_N;
        end else begin
            touch_detect_n_o <= ~pen_s;
            alert_n_o        <= ~((|gpio_data) | range_fault);
            result_ready_n_o <= ~fifo_out_valid;
        end
    end

endmodule

//--- testbench/tsd_host_model.sv
// host serial master model for the touch digitizer
// assumes idle-low shift clock of 32 ns period, clock still between frames
`timescale 1ns/1ps

module tsd_host_model (
    output logic shift_clock_o,
    output logic cs_n_o,
    output logic sdi_o,
    input  wire  sdo_i,
    input  wire  sdo_oe_i
);
    initial begin
        shift_clock_o = 1'b0;
        cs_n_o        = 1'b1;
        sdi_o         = 1'b0;
    end

    // --------------------------------------------------------------
    // one frame of nbits, msb first; released line shows inverse
    // --------------------------------------------------------------
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        #1.3;
        cs_n_o = 1'b0;
        sdi_o  = tx[15];
        #32;
        for (int i = 15; i > 15 - nbits; i--) begin
            shift_clock_o = 1'b1;
            #16;
            rx[i] = sdo_oe_i ? sdo_i : ~sdo_i;
            shift_clock_o = 1'b0;
            sdi_o = (i > 0) ? tx[i-1] : ~tx[0];
            #16;
        end
        #16;
        cs_n_o = 1'b1;
        sdi_o  = ~sdi_o;
    endtask
endmodule

//--- testbench/tsd_pin_if_sva.sv
// assertions on the ports of the touch digitizer pin interface
// assumes binding into tsd_pin_if, single clock domain clk_i
`timescale 1ns/1ps

module tsd_pin_if_sva #(
    parameter [7:0] ACQ_CYCLES = 8'h10
) (
    input wire       clk_i,
    input wire       rst_i,
    input wire       cs_n_i,
    input wire       sdo_oe_o,
    input wire       rx_valid_o,
    input wire       acquisition_hold_i,
    input wire       pen_contact_i,
    input wire       touch_detect_n_o,
    input wire [2:0] conv_chan_i,
    input wire [2:0] aux_gpio_en_i,
    input wire [7:0] mux_sel_o,
    input wire       acq_active_o,
    input wire       conv_start_o,
    input wire       conv_done_i,
    input wire       aux1_oor_i,
    input wire       temp_oor_i,
    input wire       supply1_oor_i,
    input wire       supply2_oor_i,
    input wire       alert_n_o,
    input wire       result_ready_n_o
);
    localparam int ACQ_MAX = ACQ_CYCLES + 6;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    property p_touch_low;
        pen_contact_i [*4] |-> !touch_detect_n_o;
    endproperty
    a_touch_low: assert property (p_touch_low)
        else $error("touch output not low on contact");
    property p_touch_idle;
        !pen_contact_i [*4] |-> touch_detect_n_o;
    endproperty
    a_touch_idle: assert property (p_touch_idle)
        else $error("touch output not idle high");
    property p_oe_on;
        !cs_n_i [*4] |-> sdo_oe_o;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("serial output not enabled while selected");
    property p_oe_off;
        cs_n_i [*4] |-> !sdo_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("serial output driven while deselected");
    property p_rx_sel;
        rx_valid_o |-> !$past(cs_n_i, 4);
    endproperty
    a_rx_sel: assert property (p_rx_sel)
        else $error("word received outside selection");
    property p_mux;
        acq_active_o |-> mux_sel_o == ((8'h01 << conv_chan_i) & ~{2'h0, aux_gpio_en_i, 3'h0});
    endproperty
    a_mux: assert property (p_mux)
        else $error("mux select wrong for channel");
    property p_hold;
        acquisition_hold_i [*5] |-> !acq_active_o && !conv_start_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("acquisition while held");
    property p_acq_done;
        $rose(acq_active_o) && !acquisition_hold_i |-> ##[1:ACQ_MAX] conv_start_o;
    endproperty
    a_acq_done: assert property (p_acq_done)
        else $error("conversion not started after acquisition");
    property p_alert;
        aux1_oor_i || temp_oor_i || supply1_oor_i || supply2_oor_i |-> ##[1:2] !alert_n_o;
    endproperty
    a_alert: assert property (p_alert)
        else $error("alert not low on range fault");
    property p_ready;
        conv_done_i |-> ##[2:6] !result_ready_n_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("result ready not low after conversion");
endmodule

//--- testbench/tsd_pin_if_tb_top.sv
// self-checking bench for the touch digitizer pin interface
// assumes host model and converter model; result buffer reached through the top
`timescale 1ns/1ps

module tsd_pin_if_tb_top;
    logic        clk_i, rst_i, hold, pen, cdone, oor1, oor2, oor3, oor4;
    logic [2:0]  chan, aux_en;
    logic [3:0]  gdir, gout, gext;
    logic [11:0] cdata;
    logic [7:0]  seen_mux;
    logic [15:0] exp_q[$];
    wire         sck, cs_n, sdi, sdo, sdo_oe, touch_n, acq_act, cstart, alert_n, ready_n, rxv;
    wire  [7:0]  mux;
    wire  [3:0]  gpo, gpoe, gin;
    wire  [15:0] rx_word;
    wire  [3:0]  gpi = (gpoe & gpo) | (~gpoe & gext);
    int          n_mismatch, checks, cyc, n_rxv, n_start, ccnt;

    tsd_pin_if #(.ACQ_CYCLES(8'h02)) i_tsd_pin_if (
        .clk_i(clk_i), .rst_i(rst_i), .shift_clock_i(sck), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .acquisition_hold_i(hold), .pen_contact_i(pen), .touch_detect_n_o(touch_n),
        .conv_chan_i(chan), .mux_sel_o(mux), .acq_active_o(acq_act), .conv_start_o(cstart),
        .conv_done_i(cdone), .conv_data_i(cdata), .aux1_oor_i(oor1), .temp_oor_i(oor2),
        .supply1_oor_i(oor3), .supply2_oor_i(oor4), .alert_n_o(alert_n), .result_ready_n_o(ready_n),
        .aux_gpio_en_i(aux_en), .gpio_dir_i(gdir), .gpio_out_i(gout), .gpio_pin_i(gpi),
        .gpio_pin_o(gpo), .gpio_pin_oe_o(gpoe), .gpio_in_o(gin), .rx_word_o(rx_word), .rx_valid_o(rxv));
    tsd_host_model i_tsd_host_model (.shift_clock_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe));

    // --------------------------------------------------------------
    // clock, converter model, monitors
    // --------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        cdone <= 1'b0;
        if (cstart === 1'b1) ccnt <= 3;
        else if (ccnt > 0) ccnt <= ccnt - 1;
        if (cstart === 1'b1) n_start++;
        if (ccnt == 1) begin
            cdone <= 1'b1;
            cdata <= {4'h9, 5'h00, chan};
            exp_q.push_back({1'b0, chan, 4'h9, 5'h00, chan});
        end
    end
    always @(posedge clk_i) begin
        cyc++;
        if (rxv === 1'b1) n_rxv++;
        if (acq_act === 1'b1) seen_mux = mux;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic frame(input logic [15:0] tx, input int nbits);
        logic [15:0] rx, exp;
        exp = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
        seen_mux = 8'hff;
        i_tsd_host_model.xfer(tx, nbits, rx);
        if (nbits == 16) begin
            chk(rx, exp);
            chk(rx_word, tx);
        end
        wt(8);
        chk(sdo_oe, 1'b0);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic sc_channels();
        for (int c = 0; c < 8; c++) begin
            chan = c[2:0];
            frame(16'h8421 ^ (16'h0001 << c), 16);
            chk(seen_mux, 8'h01 << c);
            chk(ready_n, 1'b0);
        end
        aux_en = 3'h1;
        chan = 3'h3;
        frame(16'h5aa5, 16);
        chk(seen_mux, 8'h00);
        aux_en = 3'h0;
    endtask
    task automatic sc_abort();
        int n0;
        n0 = n_rxv;
        frame(16'hffff, 5);
        chk(n_rxv, n0);
        frame(16'h1234, 16);
        chk(n_rxv, n0 + 1);
    endtask
    task automatic sc_hold();
        int n0;
        hold = 1'b1;
        wt(4);
        n0 = n_start;
        frame(16'h0f0f, 16);
        chk(n_start, n0);
        chk(ready_n, 1'b1);
        hold = 1'b0;
        wt(30);
        chk(n_start, n0 + 1);
        chk(ready_n, 1'b0);
    endtask
    task automatic sc_touch_alert();
        pen = 1'b1;
        wt(6);
        chk(touch_n, 1'b0);
        pen = 1'b0;
        wt(6);
        chk(touch_n, 1'b1);
        for (int i = 0; i < 4; i++) begin
            {oor4, oor3, oor2, oor1} = 4'h1 << i;
            wt(3);
            chk(alert_n, 1'b0);
            {oor4, oor3, oor2, oor1} = 4'h0;
            wt(3);
            chk(alert_n, 1'b1);
        end
        gdir = 4'h8;
        gout = 4'h8;
        wt(3);
        chk(gpoe, 4'h8);
        chk(gpo, 4'h8);
        chk(alert_n, 1'b0);
        gout = 4'h0;
        gdir = 4'h0;
        aux_en = 3'h1;
        gext = 4'h1;
        wt(6);
        chk(gin, 4'h1);
        chk(alert_n, 1'b0);
        aux_en = 3'h0;
        wt(6);
        chk(alert_n, 1'b1);
        gext = 4'h0;
    endtask
    task automatic sc_fifo();
        logic [15:0] rx;
        hold = 1'b1;
        wt(4);
        frame(16'h3c3c, 16);
        chk(ready_n, 1'b1);
        i_tsd_host_model.xfer(16'hc3c3, 16, rx);
        chk(rx, 16'h0000);
        chk(rx_word, 16'hc3c3);
        hold = 1'b0;
        wt(30);
        chk(ready_n, 1'b0);
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {rst_i, hold, pen, oor1, oor2, oor3, oor4} = 7'h40;
        {chan, aux_en, gdir, gout, gext} = 0;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        wt(4);
        chk(touch_n, 1'b1);
        chk(ready_n, 1'b1);
        chk(sdo_oe, 1'b0);
        sc_channels();
        sc_abort();
        sc_hold();
        sc_touch_alert();
        sc_fifo();
        give_verdict();
    end
endmodule

bind tsd_pin_if tsd_pin_if_sva #(.ACQ_CYCLES(ACQ_CYCLES)) i_tsd_pin_if_sva (.clk_i, .rst_i, .cs_n_i,
    .sdo_oe_o, .rx_valid_o, .acquisition_hold_i, .pen_contact_i, .touch_detect_n_o, .conv_chan_i,
    .aux_gpio_en_i, .mux_sel_o, .acq_active_o, .conv_start_o, .conv_done_i, .aux1_oor_i, .temp_oor_i,
    .supply1_oor_i, .supply2_oor_i, .alert_n_o, .result_ready_n_o);
